// >>> hw/dma_req_pkg.sv
/*
  Constants for the per-channel DMA trigger block: register offsets,
  field positions, reset values and request source codes.
  Assumes a 32-bit APB master and peripheral request pulses on clk_sys.
*/
// What this block does
// - a software write of one to the force bit starts exactly one transfer while the channel is enabled.
// - with the force bit at zero only the selected peripheral request starts.
// - writing zero to the force bit does nothing; only hardware clears it.
// - the force bit clears when its transfer ends or the channel is disabled.
// - bits 14 to 8 of the request register read zero and ignore writes.
// - codes 00,01,02,05,06,07 select int 0, ic1, oc1, ic2, oc2, timer 2.
// - codes 25,26,19,1D,1C select ic3, ic4, oc3, oc4 and timer 5.
// - codes 21,1F,0D,22 select spi 2, uart 2 tx, uart 1 tx and can rx.
// - code 46 selects can tx, only on variants that have the can unit.
package dma_req_pkg;

  // register byte offsets
  localparam logic [11:0] request_select_offset = 12'h000;
  localparam logic [11:0] channel_control_offset = 12'h004;
  localparam logic [11:0] channel_status_offset = 12'h008;

  // field positions and reset values
  localparam int force_bit = 15;
  localparam int source_msb = 7;
  localparam int enable_bit = 0;
  localparam int busy_bit = 0;
  localparam int forced_busy_bit = 1;
  localparam int pending_bit = 2;
  localparam logic [7:0] source_reset = 8'h00;

  // number of peripheral request lines
  localparam int source_count = 16;

  // request source codes
  localparam logic [7:0] code_external_interrupt_zero = 8'h00;
  localparam logic [7:0] code_input_capture_one = 8'h01;
  localparam logic [7:0] code_output_compare_one = 8'h02;
  localparam logic [7:0] code_input_capture_two = 8'h05;
  localparam logic [7:0] code_output_compare_two = 8'h06;
  localparam logic [7:0] code_timer_two = 8'h07;
  localparam logic [7:0] code_first_uart_transmitter = 8'h0D;
  localparam logic [7:0] code_output_compare_three = 8'h19;
  localparam logic [7:0] code_timer_five = 8'h1C;
  localparam logic [7:0] code_output_compare_four = 8'h1D;
  localparam logic [7:0] code_second_uart_transmitter = 8'h1F;
  localparam logic [7:0] code_second_spi_unit = 8'h21;
  localparam logic [7:0] code_can_receive_ready = 8'h22;
  localparam logic [7:0] code_input_capture_three = 8'h25;
  localparam logic [7:0] code_input_capture_four = 8'h26;
  localparam logic [7:0] code_can_transmit_request = 8'h46;

  // channel sequencing states
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_busy = 2'b01
  } chan_state_e;

endpackage

// >>> hw/dma_request_select_force.sv
/*
  Trigger logic of one DMA channel: request source select, manual force,
  channel enable and transfer start sequencing, with an APB register slave.
  Assumes peripheral requests and transfer_done are one-cycle pulses from
  logic on clk_sys; transfer_done follows every transfer_start.
  Variants without the can unit set has_can_controller_unit to zero; the
  can transmit code then selects nothing.
*/
`timescale 1ns/100ps
`default_nettype none

module dma_request_select_force #(
  parameter bit has_can_controller_unit = 1'b1
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // peripheral requests, one line per source index
  input  wire logic [15:0] peripheral_request,
  // dma channel link
  input  wire logic        transfer_done,
  output logic             transfer_start,
  output logic             transfer_forced,
  output logic             channel_enable
);

  // software visible state
  logic [7:0]               request_source_select;
  logic                     force_trigger;
  logic                     force_started;
  logic                     pending_request;
  dma_req_pkg::chan_state_e state;
  dma_req_pkg::chan_state_e next_state;

  // bus decode
  logic apb_access;
  logic apb_write;
  logic hit_select;
  logic hit_control;
  logic hit_status;
  logic mapped;

  // trigger decode
  logic [4:0] source_index;
  logic       source_valid;
  logic       selected_request;
  logic       take_request;
  logic       take_force;
  logic       start_now;
  logic       done_now;
  logic       write_force_one;
  logic       force_clear_now;
  logic       force_set_now;

  // next values of the registers
  logic        next_force_trigger;
  logic        next_force_started;
  logic        next_pending_request;
  logic [31:0] next_prdata;

  // apb answer timing
  logic answer_due;

  // apb access phase, taken at the edge where pready is high
  // pready is registered, which gives every access exactly one wait state
  assign apb_access = psel && penable && pready;
  assign apb_write = apb_access && pwrite;
  assign hit_select = paddr == dma_req_pkg::request_select_offset;
  assign hit_control = paddr == dma_req_pkg::channel_control_offset;
  assign hit_status = paddr == dma_req_pkg::channel_status_offset;
  assign mapped = hit_select || hit_control || hit_status;
  // first access cycle: read data is gathered here, one edge ahead
  assign answer_due = psel && penable && !pready;

  // source code to request line index; unknown codes, and the can transmit
  // code on a variant without the can unit, select nothing, so a stray
  // value written by software can never start transfers
  always_comb begin
    source_index = 5'h00;
    source_valid = 1'b1;
    unique case (request_source_select)
      dma_req_pkg::code_external_interrupt_zero: source_index = 5'h00;
      dma_req_pkg::code_input_capture_one:       source_index = 5'h01;
      dma_req_pkg::code_output_compare_one:      source_index = 5'h02;
      dma_req_pkg::code_input_capture_two:       source_index = 5'h03;
      dma_req_pkg::code_output_compare_two:      source_index = 5'h04;
      dma_req_pkg::code_timer_two:               source_index = 5'h05;
      dma_req_pkg::code_input_capture_three:     source_index = 5'h06;
      dma_req_pkg::code_input_capture_four:      source_index = 5'h07;
      dma_req_pkg::code_output_compare_three:    source_index = 5'h08;
      dma_req_pkg::code_output_compare_four:     source_index = 5'h09;
      dma_req_pkg::code_timer_five:              source_index = 5'h0A;
      dma_req_pkg::code_second_spi_unit:         source_index = 5'h0B;
      dma_req_pkg::code_second_uart_transmitter: source_index = 5'h0C;
      dma_req_pkg::code_first_uart_transmitter:  source_index = 5'h0D;
      dma_req_pkg::code_can_receive_ready:       source_index = 5'h0E;
      dma_req_pkg::code_can_transmit_request: begin
        source_index = 5'h0F;
        source_valid = has_can_controller_unit;
      end
      default: source_valid = 1'b0;
    endcase
  end

  // selected request line; unknown codes never trigger
  assign selected_request = source_valid &&
                            peripheral_request[source_index[3:0]];

  // peripheral requests are not looked at while the force bit is set
  // automatic mode only
  assign take_request = channel_enable && !force_trigger && selected_request;
  assign take_force = channel_enable && force_trigger && !force_started;
  // end of the running transfer; a done seen while idle is ignored
  assign done_now = (state == dma_req_pkg::st_busy) && transfer_done;
  // a start comes only from idle, so each transfer_done pairs with one start
  // start one transfer each
  assign start_now = channel_enable && (state == dma_req_pkg::st_idle) &&
                     (take_force || (!force_trigger &&
                     (selected_request || pending_request)));
  // a written zero is never looked at
  // only a one sets it
  assign write_force_one = apb_write && hit_select &&
                           pwdata[dma_req_pkg::force_bit];

  // channel state sequencing; a disable drops the channel back to idle, so
  // a transfer that never reports its end cannot hang the trigger logic;
  // the busy state is left by transfer_done
  always_comb begin
    next_state = state;
    unique case (state)
      dma_req_pkg::st_idle: begin
        if (start_now) begin
          next_state = dma_req_pkg::st_busy;
        end
      end
      dma_req_pkg::st_busy: begin
        if (!channel_enable || transfer_done) begin
          next_state = dma_req_pkg::st_idle;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= dma_req_pkg::st_idle;
    end else begin
      state <= next_state;
    end
  end

  // request source field and channel enable; the source field may be
  // rewritten at any time and applies from the next request on, and a
  // request pending from the old source is still served
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      request_source_select <= dma_req_pkg::source_reset;
      channel_enable <= 1'b0;
    end else begin
      if (apb_write && hit_select) begin
        request_source_select <= pwdata[dma_req_pkg::source_msb:0];
      end
      if (apb_write && hit_control) begin
        channel_enable <= pwdata[dma_req_pkg::enable_bit];
      end
    end
  end

  // the forced transfer has ended, or the channel has been switched off
  // hardware clear terms
  assign force_clear_now = !channel_enable ||
                           (done_now && transfer_forced);
  // a set that meets the hardware clear wins, so a one written on the last
  // cycle of a forced transfer still forces the next one; a one written
  // while a forced transfer is under way is not a second request
  // set by a one
  assign force_set_now = write_force_one &&
                         (!force_trigger || force_clear_now);

  // next force bit and its started marker
  always_comb begin
    next_force_trigger = force_trigger;
    next_force_started = force_started;
    if (force_set_now) begin
      next_force_trigger = 1'b1;
      next_force_started = 1'b0;
    end else if (force_clear_now) begin
      next_force_trigger = 1'b0;
      next_force_started = 1'b0;
    end else if (take_force && start_now) begin
      next_force_started = 1'b1;
    end
  end

  // force bit register; the started marker keeps a set force bit from
  // launching a second transfer while the first one is still running
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      force_trigger <= 1'b0;
      force_started <= 1'b0;
    end else begin
      force_trigger <= next_force_trigger;
      force_started <= next_force_started;
    end
  end

  // next held request; one request seen while busy is kept so that it is
  // not lost, further ones collapse into it; a force or a disable drops it
  always_comb begin
    next_pending_request = pending_request;
    if (!channel_enable || force_trigger) begin
      next_pending_request = 1'b0;
    end else if (take_request && !start_now) begin
      next_pending_request = 1'b1;
    end else if (start_now) begin
      next_pending_request = 1'b0;
    end
  end

  // held request register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pending_request <= 1'b0;
    end else begin
      pending_request <= next_pending_request;
    end
  end

  // start pulse towards the channel, one cycle per accepted request;
  // the channel takes this pulse as its start command
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      transfer_start <= 1'b0;
    end else begin
      transfer_start <= start_now;
    end
  end

  // forced marker: stands from a forced start until that transfer ends or
  // the channel is switched off, so the force clear can rely on it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      transfer_forced <= 1'b0;
    end else if (start_now) begin
      transfer_forced <= take_force;
    end else if (done_now || !channel_enable) begin
      transfer_forced <= 1'b0;
    end
  end

  // read data gathered in the first access cycle, zero elsewhere; reads
  // have no side effects, so the status word may be read at any time
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (answer_due && !pwrite) begin
      if (hit_select) begin
        next_prdata[dma_req_pkg::force_bit] = force_trigger;
        next_prdata[dma_req_pkg::source_msb:0] = request_source_select;
      end
      if (hit_control) begin
        next_prdata[dma_req_pkg::enable_bit] = channel_enable;
      end
      if (hit_status) begin
        next_prdata[dma_req_pkg::busy_bit] = state == dma_req_pkg::st_busy;
        next_prdata[dma_req_pkg::forced_busy_bit] = transfer_forced;
        next_prdata[dma_req_pkg::pending_bit] = pending_request;
      end
    end
  end

  // apb answer: one wait state, then pready, pslverr and data for a cycle;
  // an unmapped address answers with pslverr and reads zero, and a write
  // to it changes nothing
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= answer_due;
      pslverr <= answer_due && !mapped;
      prdata <= next_prdata;
    end
  end

endmodule

`default_nettype wire

// >>> verification/dma_rsf_chk.sv
/* assertions on the ports of dma_request_select_force
   assumes one clock clk_sys and synchronous active high reset */
`timescale 1ns/100ps
`default_nettype none
module dma_rsf_chk (
  // watched ports
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        transfer_done,
  input wire logic        transfer_start,
  input wire logic        transfer_forced,
  input wire logic        channel_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic mapped;
  // decoded register hit
  assign mapped = paddr == dma_req_pkg::request_select_offset ||
    paddr == dma_req_pkg::channel_control_offset ||
    paddr == dma_req_pkg::channel_status_offset;
  a_one_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not in second access cycle");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_map: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match decode");
  a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_rsvd_zero: assert property (
    pready && !pwrite && paddr == 12'h000 |-> prdata[14:8] == 7'h00)
    else $error("reserved bits read nonzero");
  a_start_enabled: assert property (
    transfer_start |-> $past(channel_enable))
    else $error("start while disabled");
  a_enable_write: assert property (
    pready && pwrite && paddr == 12'h004 |=> channel_enable == $past(pwdata[0]))
    else $error("enable not written");
  a_disable_clears: assert property (
    $fell(channel_enable) |=> !transfer_forced)
    else $error("forced left after disable");
  a_done_clears: assert property (
    transfer_forced && transfer_done |=> !transfer_forced)
    else $error("forced left after done");
  c_forced: cover property (transfer_start && transfer_forced);
  c_auto: cover property (transfer_start && !transfer_forced);
  c_err: cover property (pready && pslverr);
endmodule
bind dma_request_select_force dma_rsf_chk chk_u (.clk_sys, .reset, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
  .transfer_done, .transfer_start, .transfer_forced, .channel_enable);
`default_nettype wire

// >>> verification/periph_model.sv
/* peripherals and transfer engine around the trigger block
   assumes the bench pulses fire for one cycle */
`timescale 1ns/100ps
`default_nettype none
module periph_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // bench control
  input  wire logic [15:0] fire,
  input  wire logic [7:0]  done_wait,
  // channel side
  input  wire logic        transfer_start,
  output logic [15:0]      peripheral_request,
  output logic             transfer_done
);
  logic [7:0] cnt;
  logic       busy;
  // one-cycle request pulses
  always_ff @(posedge clk_sys)
    peripheral_request <= reset ? 16'h0000 : fire;
  // finish each transfer done_wait + 2 cycles after its start pulse
  always_ff @(posedge clk_sys) begin
    transfer_done <= 1'b0;
    if (reset) busy <= 1'b0;
    else if (transfer_start) begin
      busy <= 1'b1;
      cnt <= done_wait;
    end else if (busy && cnt == 8'h00) begin
      busy <= 1'b0;
      transfer_done <= 1'b1;
    end else if (busy) cnt <= cnt - 8'h01;
  end
endmodule
`default_nettype wire

// >>> verification/dma_request_select_force_tb_top.sv
/* bench for the dma trigger block: apb tasks and call sequences
   assumes periph_model as far side, clk_sys at 100 MHz */
`timescale 1ns/100ps
`default_nettype none
module dma_request_select_force_tb_top;
  localparam logic [11:0] sel_a = dma_req_pkg::request_select_offset;
  localparam logic [11:0] ctl_a = dma_req_pkg::channel_control_offset;
  localparam logic [11:0] sta_a = dma_req_pkg::channel_status_offset;
  localparam logic [7:0] codes [16] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h06,
    8'h07, 8'h25, 8'h26, 8'h19, 8'h1D, 8'h1C, 8'h21, 8'h1F, 8'h0D, 8'h22,
    8'h46};
  logic        clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, transfer_done, err, forced_seen;
  logic        transfer_start, transfer_forced, channel_enable;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] peripheral_request, fire = 16'h0000;
  logic [7:0]  done_wait = 8'h00;
  int          fail_count = 0, samples_checked = 0, starts = 0, s;
  always #5 clk_sys = ~clk_sys;
  dma_request_select_force dut_u (.clk_sys, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .peripheral_request, .transfer_done, .transfer_start, .transfer_forced,
    .channel_enable);
  periph_model model_u (.clk_sys, .reset, .fire, .done_wait,
    .transfer_start, .peripheral_request, .transfer_done);
  // count started transfers
  always @(posedge clk_sys) if (transfer_start === 1'b1) begin
    starts++;
    forced_seen = transfer_forced;
  end
  task automatic check(input string n, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_sys) penable <= 1'b1;
    // hold until pready; only the watchdog ends a hang
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rchk(input string n, input logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(n, rd, e);
  endtask
  task automatic pulse(input int i);
    @(posedge clk_sys) fire <= 16'(1 << i);
    @(posedge clk_sys) fire <= 16'h0000;
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    print_verdict;
  end
  // test sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    rchk("select reset", sel_a, 32'h0);
    apb(1'b1, sel_a, 32'h00007F25);
    rchk("reserved", sel_a, 32'h25);
    apb(1'b0, 12'hFFC, 32'h0);
    check("unmapped", {rd[30:0], err}, 32'h1);
    $display("registers test done");
    apb(1'b1, ctl_a, 32'h1);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, sel_a, {24'h0, codes[i]});
      s = starts;
      pulse((i + 1) % 16);
      check("other line", 32'(starts), 32'(s));
      pulse(i);
      check("source", 32'(starts), 32'(s + 1));
      check("auto flag", {31'h0, forced_seen}, 32'h0);
    end
    apb(1'b1, sel_a, 32'h0003);
    s = starts;
    for (int i = 0; i < 16; i++) pulse(i);
    check("unknown code", 32'(starts), 32'(s));
    $display("sources test done");
    done_wait <= 8'h1E;
    s = starts;
    apb(1'b1, sel_a, 32'h8007);
    pulse(5);
    apb(1'b1, sel_a, 32'h0007);
    rchk("force held", sel_a, 32'h8007);
    rchk("status forced", sta_a, 32'h3);
    repeat (40) @(posedge clk_sys);
    check("one forced", 32'(starts), 32'(s + 1));
    check("forced flag", {31'h0, forced_seen}, 32'h1);
    rchk("force done", sel_a, 32'h7);
    rchk("status idle", sta_a, 32'h0);
    $display("force test done");
    s = starts;
    pulse(5);
    pulse(5);
    rchk("status pending", sta_a, 32'h5);
    repeat (80) @(posedge clk_sys);
    check("pending start", 32'(starts), 32'(s + 2));
    $display("pending test done");
    apb(1'b1, sel_a, 32'h8007);
    apb(1'b1, ctl_a, 32'h0);
    rchk("force disable", sel_a, 32'h7);
    repeat (40) @(posedge clk_sys);
    s = starts;
    pulse(5);
    check("disabled", 32'(starts), 32'(s));
    $display("disable test done");
    print_verdict;
  end
endmodule
`default_nettype wire
